// >>> src/annp_pkg.sv
// Constants for the auto-negotiation next page register pair.
package annp_pkg;

   // ---------------------------------------------------------------
   // Register bus geometry
   // ---------------------------------------------------------------

   // Width of the management register address.
   localparam int ANNP_AW = 5;
   // Width of every management register.
   localparam int ANNP_DW = 16;

   // Offset of the local transmit next page register.
   localparam logic [ANNP_AW-1:0] ANNP_LOCAL_TX_OFF   = 5'h07;
   // Offset of the received partner next page register.
   localparam logic [ANNP_AW-1:0] ANNP_PARTNER_RX_OFF = 5'h08;

   // ---------------------------------------------------------------
   // Field positions, shared by both next page words
   // ---------------------------------------------------------------

   localparam int ANNP_NP_BIT   = 15;  // More next pages follow.
   localparam int ANNP_ACK_BIT  = 14;  // Acknowledge.
   localparam int ANNP_MP_BIT   = 13;  // Message page.
   localparam int ANNP_ACK2_BIT = 12;  // Can comply with message.
   localparam int ANNP_TOG_BIT  = 11;  // Toggle.
   localparam int ANNP_CODE_HI  = 10;  // Top bit of the code field.
   localparam int ANNP_CODE_W   = 11;  // Width of the code field.

   // ---------------------------------------------------------------
   // Values after reset
   // ---------------------------------------------------------------

   localparam logic                   ANNP_NP_RST   = 1'h0;
   localparam logic                   ANNP_MP_RST   = 1'h1;
   localparam logic                   ANNP_ACK2_RST = 1'h0;
   localparam logic                   ANNP_TOG_RST  = 1'h0;
   // Code one is the null message page.
   localparam logic [ANNP_CODE_W-1:0] ANNP_CODE_RST = 11'h001;
   localparam logic [ANNP_DW-1:0]     ANNP_PRX_RST  = 16'h0000;
   // Answer on a read of an unmapped address, and between reads.
   localparam logic [ANNP_DW-1:0]     ANNP_RD_IDLE  = 16'h0000;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------

   // True when the bus address selects the given register offset.
   function automatic logic annp_hit(input logic [ANNP_AW-1:0] addr,
                                     input logic [ANNP_AW-1:0] off);
      annp_hit = (addr == off);
   endfunction

endpackage

// >>> src/annp_next_page_regs.sv
// Auto-negotiation next page transmit and receive register pair.
//
// Notes on behaviour
// RULE1 - Local bit 12 writable comply flag, resets 0.
// RULE2 - Local bit 11 read-only, inverse of previous toggle.
// RULE3 - Toggle alternates on each successive page sent.
// RULE4 - Local bits 10:0 writable code field.
// RULE5 - Local code field resets to null page one.
// RULE6 - Partner bit 15: more pages coming, reset 0.
// RULE7 - Partner bit 14: partner acknowledge, reset 0.
// RULE8 - Partner bit 13: message page marker, reset 0.
// RULE9 - Partner bit 12: partner can comply, reset 0.
// RULE10 - Partner bit 11: partner toggle, reset 0.
// RULE11 - Partner bits 10:0 received code, reset 0.
// RULE12 - Whole partner register updates on accepted page.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps

module annp_next_page_regs (
   input  wire logic                           ref_clk,
   input  wire logic                           reset,
   // Management register port.
   input  wire logic [annp_pkg::ANNP_AW-1:0]   reg_addr,
   input  wire logic [annp_pkg::ANNP_DW-1:0]   reg_wdata,
   input  wire logic                           reg_wr,
   input  wire logic                           reg_rd,
   output logic      [annp_pkg::ANNP_DW-1:0]   reg_rdata,
   // Arbitration side: local page on its way out.
   input  wire logic                           tx_page_sent,
   input  wire logic                           tx_sent_toggle,
   output logic      [annp_pkg::ANNP_DW-1:0]   tx_page_word,
   // Arbitration side: page accepted from the link partner.
   input  wire logic                           rx_page_valid,
   input  wire logic [annp_pkg::ANNP_DW-1:0]   rx_page_word
);
   import annp_pkg::*;

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------

   logic                   np_ff;        // Local more-pages flag.
   logic                   mp_ff;        // Local message page flag.
   logic                   ack2_ff;      // Local comply flag.
   logic                   tog_ff;       // Local toggle, hardware owned.
   logic [ANNP_CODE_W-1:0] code_ff;      // Local code field.
   logic [ANNP_DW-1:0]     prx_ff;       // Last accepted partner page.
   logic [ANNP_DW-1:0]     rd_data_ff;   // Read answer register.
   logic [ANNP_DW-1:0]     nxt_rd_data;  // Next read answer.
   logic [ANNP_DW-1:0]     ltx_view;     // Local register as read.
   logic                   ltx_wr;       // Write to the local register.

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------

   // A write strobe aimed at the local transmit register. Writes to
   // the partner register or unmapped addresses have no effect.
   assign ltx_wr = reg_wr && annp_hit(reg_addr, ANNP_LOCAL_TX_OFF);

   // The local register as software sees it. The reserved bit 14
   // reads as zero; the acknowledge of the outgoing word is added
   // by arbitration, not held here.
   always_comb begin
      ltx_view                           = '0;
      ltx_view[ANNP_NP_BIT]              = np_ff;
      ltx_view[ANNP_MP_BIT]              = mp_ff;
      ltx_view[ANNP_ACK2_BIT]            = ack2_ff;
      ltx_view[ANNP_TOG_BIT]             = tog_ff;
      ltx_view[ANNP_CODE_HI:0]           = code_ff;
   end

   // The page offered to arbitration is built straight from the
   // stored fields, so it carries the current toggle. [RULE3]
   assign tx_page_word = ltx_view;

   // ---------------------------------------------------------------
   // Local transmit register: software fields
   // ---------------------------------------------------------------

   // Next page and message page flags.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         np_ff <= ANNP_NP_RST;
         mp_ff <= ANNP_MP_RST;
      end else if (ltx_wr) begin
         np_ff <= reg_wdata[ANNP_NP_BIT];
         mp_ff <= reg_wdata[ANNP_MP_BIT];
      end
   end

   // Comply flag: one means the local side will act on the message.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ack2_ff <= ANNP_ACK2_RST;                         // [RULE1]
      end else if (ltx_wr) begin
         ack2_ff <= reg_wdata[ANNP_ACK2_BIT];              // [RULE1]
      end
   end

   // Code field: message code when the message page flag is set,
   // otherwise an application defined unformatted code.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         code_ff <= ANNP_CODE_RST;                         // [RULE5]
      end else if (ltx_wr) begin
         code_ff <= reg_wdata[ANNP_CODE_HI:0];             // [RULE4]
      end
   end

   // ---------------------------------------------------------------
   // Local transmit register: toggle
   // ---------------------------------------------------------------

   // Software cannot write the toggle. Each time arbitration sends a
   // word it reports that word's toggle, and the next page takes the
   // opposite value, so successive pages alternate.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         tog_ff <= ANNP_TOG_RST;                           // [RULE2]
      end else if (tx_page_sent) begin
         tog_ff <= ~tx_sent_toggle;                        // [RULE2] [RULE3]
      end
   end

   // ---------------------------------------------------------------
   // Partner next page register
   // ---------------------------------------------------------------

   // All partner fields load together from one accepted word, so
   // software never sees a mix of two pages. Bus writes are ignored.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         prx_ff <= ANNP_PRX_RST;          // [RULE6] [RULE7] [RULE8]
      end else if (rx_page_valid) begin
         prx_ff <= rx_page_word;          // [RULE12] [RULE9] [RULE10]
      end
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------

   // Select the answer for a read strobe. Outside a read, and for an
   // unmapped address, the answer is zero.
   always_comb begin
      nxt_rd_data = ANNP_RD_IDLE;
      if (reg_rd) begin
         if (annp_hit(reg_addr, ANNP_LOCAL_TX_OFF)) begin
            nxt_rd_data = ltx_view;
         end else if (annp_hit(reg_addr, ANNP_PARTNER_RX_OFF)) begin
            nxt_rd_data = prx_ff;                          // [RULE11]
         end else begin
            nxt_rd_data = ANNP_RD_IDLE;
         end
      end
   end

   // Read data stands for exactly the cycle after the strobe.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rd_data_ff <= ANNP_RD_IDLE;
      end else begin
         rd_data_ff <= nxt_rd_data;
      end
   end

   assign reg_rdata = rd_data_ff;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------

   default clocking chk_clk @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   // A write to the local register sets the comply flag as written.
   chk_ack2_write: assert property (                       // [RULE1]
      ltx_wr |=> (tx_page_word[ANNP_ACK2_BIT]
                  == $past(reg_wdata[ANNP_ACK2_BIT])))
      else $error("Comply flag did not follow the write.");

   // The toggle after a sent word is the inverse of that word's.
   chk_toggle_invert: assert property (                    // [RULE2]
      tx_page_sent |=> (tx_page_word[ANNP_TOG_BIT]
                        == !$past(tx_sent_toggle)))
      else $error("Toggle is not the inverse of the sent toggle.");

   // Software writes never move the toggle.
   chk_toggle_ro: assert property (                        // [RULE2]
      (ltx_wr && !tx_page_sent) |=> $stable(tog_ff))
      else $error("Toggle changed on a bus write.");

   // Sending the offered page flips the offered toggle.
   chk_toggle_alternate: assert property (                 // [RULE3]
      (tx_page_sent && tx_sent_toggle == tx_page_word[ANNP_TOG_BIT])
      |=> (tx_page_word[ANNP_TOG_BIT]
           != $past(tx_page_word[ANNP_TOG_BIT])))
      else $error("Toggle did not alternate between pages.");

   // A write loads the code field, and a read returns it next cycle.
   chk_code_write: assert property (                       // [RULE4]
      (ltx_wr ##1 (reg_rd && annp_hit(reg_addr, ANNP_LOCAL_TX_OFF)))
      |=> (reg_rdata[ANNP_CODE_HI:0]
           == $past(reg_wdata[ANNP_CODE_HI:0], 2)))
      else $error("Code field read back differs from the write.");

   // Right after reset the code field offers the null page.
   chk_code_reset: assert property (                       // [RULE5]
      @(posedge ref_clk) disable iff (1'b0)
      $fell(reset) |-> (tx_page_word[ANNP_CODE_HI:0] == ANNP_CODE_RST))
      else $error("Code field is not the null page after reset.");

   // Partner more-pages flag comes from the accepted word.
   chk_rx_next_page: assert property (                     // [RULE6]
      rx_page_valid |=> (prx_ff[ANNP_NP_BIT]
                         == $past(rx_page_word[ANNP_NP_BIT])))
      else $error("Partner next page flag not captured.");

   // Partner acknowledge comes from the accepted word.
   chk_rx_ack: assert property (                           // [RULE7]
      rx_page_valid |=> (prx_ff[ANNP_ACK_BIT]
                         == $past(rx_page_word[ANNP_ACK_BIT])))
      else $error("Partner acknowledge not captured.");

   // Partner message page flag comes from the accepted word.
   chk_rx_msg_page: assert property (                      // [RULE8]
      rx_page_valid |=> (prx_ff[ANNP_MP_BIT]
                         == $past(rx_page_word[ANNP_MP_BIT])))
      else $error("Partner message page flag not captured.");

   // Partner comply flag comes from the accepted word.
   chk_rx_comply: assert property (                        // [RULE9]
      rx_page_valid |=> (prx_ff[ANNP_ACK2_BIT]
                         == $past(rx_page_word[ANNP_ACK2_BIT])))
      else $error("Partner comply flag not captured.");

   // Partner toggle comes from the accepted word.
   chk_rx_toggle: assert property (                        // [RULE10]
      rx_page_valid |=> (prx_ff[ANNP_TOG_BIT]
                         == $past(rx_page_word[ANNP_TOG_BIT])))
      else $error("Partner toggle not captured.");

   // A partner register read returns the held word one cycle later.
   chk_rx_read: assert property (                          // [RULE11]
      (reg_rd && annp_hit(reg_addr, ANNP_PARTNER_RX_OFF))
      |=> (reg_rdata == $past(prx_ff)))
      else $error("Partner register read returned wrong data.");

   // The partner register holds between accepted pages, bus or not.
   chk_rx_hold: assert property (                          // [RULE12]
      !rx_page_valid |=> $stable(prx_ff))
      else $error("Partner register changed without a new page.");

   // Read data is zero in any cycle not following a read strobe.
   chk_rd_idle: assert property (
      !reg_rd |=> (reg_rdata == ANNP_RD_IDLE))
      else $error("Read data present without a read strobe.");

   // With no write, the comply flag keeps its value.
   chk_ack2_hold: assert property (                        // [RULE1]
      !ltx_wr |=> $stable(ack2_ff))
      else $error("Comply flag changed without a write.");

   // The toggle only moves when arbitration reports a sent page.
   chk_toggle_hold: assert property (                      // [RULE2]
      !tx_page_sent |=> $stable(tog_ff))
      else $error("Toggle changed without a sent page.");

   // Comply flag and toggle come out of reset as zero.
   chk_local_reset: assert property (                      // [RULE1] [RULE2]
      @(posedge ref_clk) disable iff (1'b0)
      $fell(reset) |-> (tx_page_word[ANNP_ACK2_BIT] == ANNP_ACK2_RST
                        && tx_page_word[ANNP_TOG_BIT] == ANNP_TOG_RST))
      else $error("Comply flag or toggle wrong after reset.");

   // The code field keeps its value between writes.
   chk_code_hold: assert property (                        // [RULE4]
      !ltx_wr |=> $stable(code_ff))
      else $error("Code field changed without a write.");

   // A local register read returns the stored fields next cycle.
   chk_local_read: assert property (                       // [RULE4]
      (reg_rd && annp_hit(reg_addr, ANNP_LOCAL_TX_OFF))
      |=> (reg_rdata == $past(tx_page_word)))
      else $error("Local register read returned wrong data.");

   // The partner code field comes from the accepted word.
   chk_rx_code: assert property (                          // [RULE11]
      rx_page_valid |=> (prx_ff[ANNP_CODE_HI:0]
                         == $past(rx_page_word[ANNP_CODE_HI:0])))
      else $error("Partner code field not captured.");

   // The whole partner word loads at once from an accepted page.
   chk_rx_whole: assert property (                         // [RULE12]
      rx_page_valid |=> (prx_ff == $past(rx_page_word)))
      else $error("Partner word not loaded as a whole.");

   // The partner register comes out of reset as zero.
   chk_rx_reset: assert property (                         // [RULE6] [RULE11]
      @(posedge ref_clk) disable iff (1'b0)
      $fell(reset) |-> (prx_ff == ANNP_PRX_RST))
      else $error("Partner register not zero after reset.");

   // A read of an unmapped address answers zero.
   chk_rd_unmapped: assert property (
      (reg_rd && !annp_hit(reg_addr, ANNP_LOCAL_TX_OFF)
       && !annp_hit(reg_addr, ANNP_PARTNER_RX_OFF))
      |=> (reg_rdata == ANNP_RD_IDLE))
      else $error("Unmapped read returned nonzero data.");

endmodule // annp_next_page_regs

// >>> sim/annp_partner_model.sv
// Behavioural link partner and arbitration side for the next page pair.
`timescale 1ns/1ps

module annp_partner_model (
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        send_req,
   input  wire logic        recv_req,
   input  wire logic [15:0] recv_word,
   output logic             tx_page_sent,
   output logic             tx_sent_toggle,
   output logic             rx_page_valid,
   output logic [15:0]      rx_page_word
);
   logic tog_ff;  // Toggle that goes with the next local page sent.

   // One page is sent for each cycle of send_req. The reported toggle is
   // that of the page just sent, and the next page takes the opposite one.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         tx_page_sent   <= 1'b0;
         tx_sent_toggle <= 1'b0;
         tog_ff         <= 1'b0;
      end else begin
         tx_page_sent <= send_req;
         if (send_req) begin
            tx_sent_toggle <= tog_ff;
            tog_ff         <= ~tog_ff;
         end
      end
   end

   // The word is only meaningful with the valid pulse; between pulses the
   // line inverts every cycle, so the inverse and the last word alternate.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rx_page_valid <= 1'b0;
         rx_page_word  <= 16'h0000;
      end else begin
         rx_page_valid <= recv_req;
         rx_page_word  <= recv_req ? recv_word : ~rx_page_word;
      end
   end
endmodule // annp_partner_model

// >>> sim/annp_next_page_regs_tb.sv
// Self-checking bench for the next page register pair.
`timescale 1ns/1ps

module annp_next_page_regs_tb;
   import annp_pkg::*;
   logic               ref_clk = 1'b0;
   logic               reset = 1'b1;
   logic [ANNP_AW-1:0] reg_addr = '0;
   logic [ANNP_DW-1:0] reg_wdata = '0;
   logic               reg_wr = 1'b0;
   logic               reg_rd = 1'b0;
   logic [ANNP_DW-1:0] reg_rdata;
   logic [ANNP_DW-1:0] tx_page_word;
   logic               send_req = 1'b0;
   logic               recv_req = 1'b0;
   logic [15:0]        recv_word = 16'h0000;
   logic               tx_page_sent, tx_sent_toggle, rx_page_valid;
   logic [15:0]        rx_page_word;
   int                 num_errors = 0;
   int                 checks = 0;
   logic [31:0]        seed = 32'h000132AC;  // Random state.
   logic               ptog = 1'b0;       // Mirror of the local toggle.
   logic [15:0]        lw = 16'h2001;     // Last word written locally.
   logic [15:0]        pw = 16'h0000;     // Last partner word.
   logic [15:0]        w1;

   always #2 ref_clk = ~ref_clk;

   annp_next_page_regs i_annp_next_page_regs (
      .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .tx_page_sent(tx_page_sent),
      .tx_sent_toggle(tx_sent_toggle), .tx_page_word(tx_page_word),
      .rx_page_valid(rx_page_valid), .rx_page_word(rx_page_word));

   annp_partner_model i_annp_partner_model (
      .ref_clk(ref_clk), .reset(reset), .send_req(send_req),
      .recv_req(recv_req), .recv_word(recv_word),
      .tx_page_sent(tx_page_sent), .tx_sent_toggle(tx_sent_toggle),
      .rx_page_valid(rx_page_valid), .rx_page_word(rx_page_word));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------

   // Linear feedback shift register step for random stimulus.
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Local word as read back: bit 14 reads 0, bit 11 is the toggle.
   function automatic logic [15:0] exp_local(input logic [15:0] w,
                                             input logic t);
      exp_local = (w & 16'hB7FF) | {4'h0, t, 11'h000};
   endfunction

   task automatic chk(input string what, input logic [15:0] exp, got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [ANNP_AW-1:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // Read strobe for one cycle; data is taken in the cycle after it.
   task automatic rd_chk(input string what, input logic [ANNP_AW-1:0] a,
                         input logic [15:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(what, exp, reg_rdata);
   endtask

   // Write, then read the same address at the very next edge.
   task automatic wr_rd_chk(input string what, input logic [ANNP_AW-1:0] a,
                            input logic [15:0] d, exp);
      wr(a, d);
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(what, exp, reg_rdata);
   endtask

   // Arbitration sends n pages back to back.
   task automatic send(input int n);
      @(posedge ref_clk);
      send_req <= 1'b1;
      repeat (n) @(posedge ref_clk);
      send_req <= 1'b0;
      @(posedge ref_clk);
      if (n % 2 == 1) ptog = ~ptog;
      #1 chk("tx word", exp_local(lw, ptog), tx_page_word);
   endtask

   task automatic do_reset();
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      ptog = 1'b0;
      lw = 16'h2001;
      pw = 16'h0000;
      #1 chk("rst tx word", 16'h2001, tx_page_word);
      rd_chk("rst local", ANNP_LOCAL_TX_OFF, 16'h2001);
      rd_chk("rst partner", ANNP_PARTNER_RX_OFF, 16'h0000);
      $display("test reset done");
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------

   initial begin
      do_reset();
      rd_chk("unmapped", 5'h1F, 16'h0000);
      @(posedge ref_clk);
      #1 chk("rdata idle", 16'h0000, reg_rdata);
      $display("test bus done");
      // Writes with both extremes first, then random words.
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         lw = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : seed[15:0];
         w1 = exp_local(lw, ptog);
         wr_rd_chk("local", ANNP_LOCAL_TX_OFF, lw, w1);
         #1 chk("tx word", w1, tx_page_word);
         wr(ANNP_PARTNER_RX_OFF, ~lw);
         rd_chk("ro partner", ANNP_PARTNER_RX_OFF, pw);
      end
      $display("test writes done");
      for (int n = 1; n <= 4; n++) send(n);
      $display("test toggle done");
      // An all-ones partner page, then random pages, then a back-to-back pair.
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         pw = (i == 0) ? 16'hFFFF : seed[15:0];
         @(posedge ref_clk);
         recv_req <= 1'b1;
         recv_word <= pw;
         if (i == 5) begin
            @(posedge ref_clk);
            w1 = ~pw ^ 16'h5A5A;
            recv_word <= w1;
            pw = w1;
         end
         @(posedge ref_clk);
         recv_req <= 1'b0;
         @(posedge ref_clk);
         rd_chk("partner", ANNP_PARTNER_RX_OFF, pw);
      end
      $display("test receive done");
      do_reset();
      tally_and_finish();
   end

   // Cuts a hang short far beyond the roughly 130 cycles the tests take.
   initial begin
      #100000;
      num_errors++;
      tally_and_finish();
   end
endmodule // annp_next_page_regs_tb
